/* File: hdl/ies_consts.vh */
`ifndef IES_CONSTS_VH
`define IES_CONSTS_VH

// Status register bit positions.
`define IES_MS_FORCE_DESC 0
`define IES_MS_INH_PFAULT 1
`define IES_MS_PERF_MON 2
`define IES_MS_NO_OVERLAP 3
`define IES_MS_OVERFLOW 4
`define IES_MS_NONZERO 5
`define IES_MS_NEGATIVE 6
`define IES_MS_BOOLEAN 7
`define IES_MS_BYP_PAGE 8
`define IES_MS_BYP_NAME 9
`define IES_MS_IC_INH 10
`define IES_MS_BD_SYSERR 11
`define IES_MS_ACC_SYSERR 12
`define IES_MS_EXEC 13
`define IES_MS_LEVEL1 14
`define IES_MS_LEVEL0 15

// Bits a user program may alter; the rest are system mode bits.
`define IES_MS_USER_MASK 16'h00f3
`define IES_MS_ALL_MASK 16'hffff
`define IES_MS_RESET 16'h0000

// Interrupt numbers, lowest is serviced first.
`define IES_INT_SYSERR 3'h0
`define IES_INT_CPR_NEQ 3'h1
`define IES_INT_EXCHANGE 3'h2
`define IES_INT_PERIPH 3'h3
`define IES_INT_ICOUNT 3'h4
`define IES_INT_ILL_ORDER 3'h5
`define IES_INT_PFAULT 3'h6
`define IES_INT_SOFTWARE 3'h7
`define IES_NUM_INT 8

// Vector table base, in 64-bit words of the first common segment.
`define IES_VEC_BASE 16'h0010

// System error status bit indices (index 0 stands for status bit 48).
`define IES_SE_CONSOLE 0
`define IES_SE_HW 1
`define IES_SE_BD 8
`define IES_SE_ACC 9
`define IES_SE_ILL_FUNC 10
`define IES_SE_PFAULT 11
`define IES_SE_CPR_NEQ 13

// Register port addresses.
`define IES_REG_STATUS 8'h00
`define IES_REG_SYSERR 8'h08
`define IES_REG_ICOUNT 8'h10
`define IES_REG_PENDING 8'h1a

`endif

/* File: hdl/ies_sticky.v */
`timescale 1ns/1ps
// Bank of sticky flags; a set in the same cycle as a clear wins.
module ies_sticky #(
	parameter W = 8
) (
	input wire clk_sys,
	input wire arst_n,
	input wire [W-1:0] set,
	input wire [W-1:0] clr,
	output reg [W-1:0] q
);
	// Clearing first and setting after keeps an arriving event from being lost.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			q <= {W{1'b0}};
		end else begin
			q <= (q & ~clr) | set;
		end
	end
endmodule // ies_sticky

/* File: hdl/ies_prio8.v */
`timescale 1ns/1ps
// Picks the lowest numbered active request of eight.
module ies_prio8 (
	input wire [7:0] req,
	output reg valid,
	output reg [2:0] idx
);
	integer i;
	// Scanning downward lets the lowest index overwrite the others.
	always @* begin
		valid = 1'b0;
		idx = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (req[i]) begin
				valid = 1'b1;
				idx = i[2:0];
			end
		end
	end
endmodule // ies_prio8

/* File: hdl/ies_entry_ctrl.v */
`timescale 1ns/1ps
`include "ies_consts.vh"
// Function
// (RL1) Eight interrupt causes, system and process groups, each with three-bit number.
// (RL2) Among pending interrupts the lowest number is serviced first.
// (RL3) Taking an interrupt halts work and sets a non-interruptible entry flag.
// (RL4) First entry step saves 64-bit link: status, name base, control address.
// (RL5) Link goes to entry I word one; new link loads from word two.
// (RL6) Vector table is sixteen 64-bit words from word 16 of segment one.
// (RL7) Page-register mismatch entry skips drain; handler preserves the operand buffer.
// (RL8) Other causes wait until all earlier instructions complete.
// (RL9) Pending unserviced interrupts are readable at status line 26.
// (RL10) Status is 16 bits; users alter only bits 0, 1, 4 to 7.
// (RL11) System mode bits 2, 3, 8 to 15 writable only when privileged.
// (RL12) Executive bit set on interrupt entry and on executive calls.
// (RL13) Low status bits: descriptor, fault inhibit, monitor, no-overlap, test bits.
// (RL14) High status bits: bypasses, counter inhibit, fault routing, executive, levels.
// (RL15) Special access allowed when bit 13, 14, 15 or entry flag set.
// (RL16) Name store bypassed while entry flag is set.
// (RL17) Faults become system errors per bits 11, 12, or privilege.
// (RL18) Level-0 flag maps operands to eight fast registers, no store access.
// (RL19) Page mismatch or illegal function under level 0 raises system error.
// (RL20) After a system error, further ones block until status reset or console.
// (RL21) Console interrupt records status bit 48 and forces page register bypass.
// (RL22) Instruction counter reaching zero interrupts unless its inhibit bit is set.
// (RL23) Level inhibits: level 1 by L1, L0, entry; level 0 by L0, entry; the code holds off system error (0) by entry only.
// (RL24) Instruction counter stops while bit 10, 14, 15 or entry set.
module ies_entry_ctrl (
	input wire clk_sys,
	input wire arst_n,
	input wire ev_cpr_neq,
	input wire ev_exchange,
	input wire ev_periph,
	input wire ev_software,
	input wire ev_ill_order,
	input wire ev_fault_bd,
	input wire ev_fault_acc,
	input wire ev_fault_other,
	input wire ev_ill_func,
	input wire ev_hw_error,
	input wire ev_console,
	input wire ins_retired,
	input wire pipe_idle,
	input wire xc_exec,
	input wire ms_wr,
	input wire [15:0] ms_wmask,
	input wire [15:0] ms_wdata,
	input wire [15:0] cur_name_base,
	input wire [31:0] cur_control_address,
	output wire halt_req,
	output wire entry_flag,
	output wire store_req,
	output wire store_we,
	output reg [15:0] store_addr,
	output reg [63:0] store_wdata,
	input wire store_ack,
	input wire [63:0] store_rdata,
	output reg link_load,
	output reg [15:0] new_name_base,
	output reg [31:0] new_control_address,
	output reg [2:0] int_number,
	output wire [15:0] machine_status,
	output wire priv_access,
	output wire bypass_page_regs,
	output wire bypass_name_store,
	output wire ic_stopped,
	input wire [15:0] opnd_addr,
	output reg fast_reg_hit,
	output reg [2:0] fast_reg_sel,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata
);
	localparam ST_IDLE = 5'h01;
	localparam ST_DRAIN = 5'h02;
	localparam ST_SAVE = 5'h04;
	localparam ST_LOAD = 5'h08;
	localparam ST_APPLY = 5'h10;

	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg [15:0] ms_reg;
	reg [15:0] ms_next;
	reg [15:0] ic_reg;
	reg [15:0] ic_next;
	reg [63:0] newlink_reg;
	reg se_block_reg;
	reg console_byp_reg;
	reg [15:0] wr_mask;
	reg [15:0] wr_data;
	wire [7:0] pend;
	reg [7:0] pend_set;
	reg [7:0] pend_clr;
	wire [15:0] se_stat;
	reg [15:0] se_set;
	wire [15:0] se_clr;
	wire [7:0] enabled;
	wire any_en;
	wire [2:0] win_idx;
	wire ms_l0;
	wire ms_l1;
	wire ms_exec;
	wire in_entry;
	wire fault_bd_se;
	wire fault_acc_se;
	wire fault_other_se;
	wire ill_func_se;
	wire cpr_se;
	wire se_event;
	wire ic_zero_ev;
	wire se_reg_wr;

	assign ms_l0 = ms_reg[`IES_MS_LEVEL0];
	assign ms_l1 = ms_reg[`IES_MS_LEVEL1];
	assign ms_exec = ms_reg[`IES_MS_EXEC];
	assign in_entry = (state_reg != ST_IDLE);
	assign entry_flag = in_entry; // see RL3
	assign halt_req = in_entry; // see RL3
	assign machine_status = ms_reg; // see RL10

	// Privilege, bypasses and counter stop, derived from status, the entry flag and the console bypass register.
	assign priv_access = ms_exec | ms_l1 | ms_l0 | in_entry; // see RL15
	assign bypass_page_regs = ms_reg[`IES_MS_BYP_PAGE] | console_byp_reg; // see RL14 see RL21
	assign bypass_name_store = ms_reg[`IES_MS_BYP_NAME] | in_entry; // see RL16
	assign ic_stopped = ms_reg[`IES_MS_IC_INH] | ms_l1 | ms_l0 | in_entry; // see RL24

	// Fault routing; a routed fault no longer reaches its normal interrupt.
	assign fault_bd_se = ev_fault_bd & ms_reg[`IES_MS_BD_SYSERR]; // see RL17
	assign fault_acc_se = ev_fault_acc & ms_reg[`IES_MS_ACC_SYSERR]; // see RL17
	assign fault_other_se = ev_fault_other & priv_access; // see RL17
	assign ill_func_se = ev_ill_func & (ms_l0 | priv_access); // see RL19 see RL17
	assign cpr_se = ev_cpr_neq & ms_l0; // see RL19
	assign se_event = |se_set;
	assign se_reg_wr = reg_wr & (reg_addr == `IES_REG_SYSERR);
	// Writing the system error status resets it, whatever data is written.
	assign se_clr = se_reg_wr ? 16'hffff : 16'h0000;

	// System error status bits; these only record causes.
	always @* begin
		se_set = 16'h0000;
		se_set[`IES_SE_CONSOLE] = ev_console; // see RL21
		se_set[`IES_SE_HW] = ev_hw_error;
		se_set[`IES_SE_BD] = fault_bd_se;
		se_set[`IES_SE_ACC] = fault_acc_se;
		se_set[`IES_SE_ILL_FUNC] = ill_func_se;
		se_set[`IES_SE_PFAULT] = fault_other_se;
		se_set[`IES_SE_CPR_NEQ] = cpr_se;
	end

	ies_sticky #(.W(16)) u_se_stat (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.set(se_set),
		.clr(se_clr),
		.q(se_stat)
	);

	// Counter zero fires only on the decrement that reaches zero.
	assign ic_zero_ev = ins_retired & ~ic_stopped & (ic_reg == 16'h0001) & ~ms_reg[`IES_MS_IC_INH]; // see RL22

	// Pending set and clear; the serviced cause is cleared as its entry completes.
	always @* begin
		pend_set = 8'h00;
		// A console press or a status reset lifts the block, so an error that arrives with it is still entered.
		pend_set[`IES_INT_SYSERR] = se_event & (~se_block_reg | ev_console | se_reg_wr); // see RL20 see RL21
		pend_set[`IES_INT_CPR_NEQ] = ev_cpr_neq & ~cpr_se; // see RL19
		pend_set[`IES_INT_EXCHANGE] = ev_exchange;
		pend_set[`IES_INT_PERIPH] = ev_periph;
		pend_set[`IES_INT_ICOUNT] = ic_zero_ev; // see RL22
		pend_set[`IES_INT_ILL_ORDER] = ev_ill_order | (ev_ill_func & ~ill_func_se);
		pend_set[`IES_INT_PFAULT] = ~ms_reg[`IES_MS_INH_PFAULT] &
			((ev_fault_bd & ~fault_bd_se) | (ev_fault_acc & ~fault_acc_se) |
			(ev_fault_other & ~fault_other_se)); // see RL13
		pend_set[`IES_INT_SOFTWARE] = ev_software;
		pend_clr = 8'h00;
		if (state_reg == ST_APPLY) begin
			pend_clr[int_number] = 1'b1;
		end
	end

	ies_sticky #(.W(`IES_NUM_INT)) u_pend (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.set(pend_set),
		.clr(pend_clr),
		.q(pend)
	);

	// Level inhibits; system errors are held off only during an entry.
	assign enabled[3:0] = {pend[3:1] & {3{~(ms_l0 | in_entry)}}, pend[0] & ~in_entry}; // see RL23
	assign enabled[7:4] = pend[7:4] & {4{~(ms_l1 | ms_l0 | in_entry)}}; // see RL23

	ies_prio8 u_prio (
		.req(enabled),
		.valid(any_en),
		.idx(win_idx)
	); // see RL2 see RL1

	// Entry sequencer next state.
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (any_en) begin
					state_next = ST_DRAIN; // see RL3
				end
			end
			ST_DRAIN: begin
				// A page mismatch enters at once and may leave an order half done.
				if (pipe_idle || (int_number == `IES_INT_CPR_NEQ)) begin
					state_next = ST_SAVE; // see RL7 see RL8
				end
			end
			ST_SAVE: begin
				if (store_ack) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (store_ack) begin
					state_next = ST_APPLY;
				end
			end
			ST_APPLY: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	assign store_req = (state_reg == ST_SAVE) || (state_reg == ST_LOAD);
	assign store_we = (state_reg == ST_SAVE); // see RL4

	// Sequencer registers, link capture and table addressing.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			int_number <= 3'h0;
			store_addr <= 16'h0000;
			store_wdata <= 64'h0000000000000000;
			newlink_reg <= 64'h0000000000000000;
			link_load <= 1'b0;
			new_name_base <= 16'h0000;
			new_control_address <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			link_load <= 1'b0;
			if ((state_reg == ST_IDLE) && any_en) begin
				int_number <= win_idx;
			end
			if ((state_reg == ST_DRAIN) && (state_next == ST_SAVE)) begin
				store_wdata <= {ms_reg, cur_name_base, cur_control_address}; // see RL4
				store_addr <= `IES_VEC_BASE + {12'h000, int_number, 1'b0}; // see RL5 see RL6
			end
			if ((state_reg == ST_SAVE) && store_ack) begin
				store_addr <= `IES_VEC_BASE + {12'h000, int_number, 1'b1}; // see RL5
			end
			if ((state_reg == ST_LOAD) && store_ack) begin
				newlink_reg <= store_rdata; // see RL5
			end
			if (state_reg == ST_APPLY) begin
				new_name_base <= newlink_reg[47:32];
				new_control_address <= newlink_reg[31:0];
				link_load <= 1'b1;
			end
		end
	end

	// Merge of status writes; register port and pipeline share the privilege gate.
	always @* begin
		wr_mask = 16'h0000;
		wr_data = ms_wdata;
		if (reg_wr && (reg_addr == `IES_REG_STATUS)) begin
			wr_mask = `IES_MS_ALL_MASK;
			wr_data = reg_wdata;
		end else if (ms_wr) begin
			wr_mask = ms_wmask;
		end
		if (!priv_access) begin
			wr_mask = wr_mask & `IES_MS_USER_MASK; // see RL10 see RL11
		end
		ms_next = (ms_reg & ~wr_mask) | (wr_data & wr_mask);
		if (xc_exec) begin
			ms_next[`IES_MS_EXEC] = 1'b1; // see RL12
		end
		// The entry link replaces the whole status, then executive mode is forced.
		if (state_reg == ST_APPLY) begin
			ms_next = newlink_reg[63:48]; // see RL5
			ms_next[`IES_MS_EXEC] = 1'b1; // see RL12
		end
	end

	// Instruction counter; software may reload it at any time.
	always @* begin
		ic_next = ic_reg;
		if (reg_wr && (reg_addr == `IES_REG_ICOUNT)) begin
			ic_next = reg_wdata;
		end else if (ins_retired && !ic_stopped) begin
			ic_next = ic_reg - 16'h0001; // see RL24
		end
	end

	// Status, counter, system error blocking and console bypass registers.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ms_reg <= `IES_MS_RESET;
			ic_reg <= 16'h0000;
			se_block_reg <= 1'b0;
			console_byp_reg <= 1'b0;
		end else begin
			ms_reg <= ms_next;
			ic_reg <= ic_next;
			// Taking a system error blocks the next; the block outlives the handler.
			if ((state_reg == ST_APPLY) && (int_number == `IES_INT_SYSERR)) begin
				se_block_reg <= 1'b1; // see RL20
			end else if (se_reg_wr || ev_console) begin
				se_block_reg <= 1'b0; // see RL20
			end
			if (ev_console) begin
				console_byp_reg <= 1'b1; // see RL21
			end else if (se_reg_wr) begin
				console_byp_reg <= 1'b0;
			end
		end
	end

	// Fast register decode; only the low three address bits matter in level 0.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fast_reg_hit <= 1'b0;
			fast_reg_sel <= 3'h0;
		end else begin
			fast_reg_hit <= ms_l0; // see RL18
			fast_reg_sel <= opnd_addr[2:0]; // see RL18
		end
	end

	// Register port read data, valid in the cycle after the strobe only.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`IES_REG_STATUS: reg_rdata <= ms_reg;
				`IES_REG_SYSERR: reg_rdata <= se_stat;
				`IES_REG_ICOUNT: reg_rdata <= ic_reg;
				`IES_REG_PENDING: reg_rdata <= {8'h00, pend}; // see RL9
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule // ies_entry_ctrl

/* File: test/ies_entry_chk_sva.sv */
`timescale 1ns/1ps
// Watches the entry sequence and the status-derived controls at the block's pins.
module ies_entry_chk (
	input wire clk_sys,
	input wire arst_n,
	input wire pipe_idle,
	input wire halt_req,
	input wire entry_flag,
	input wire store_req,
	input wire store_we,
	input wire [15:0] store_addr,
	input wire store_ack,
	input wire link_load,
	input wire [2:0] int_number,
	input wire [15:0] machine_status,
	input wire priv_access,
	input wire bypass_name_store,
	input wire ic_stopped,
	input wire [15:0] opnd_addr,
	input wire fast_reg_hit,
	input wire [2:0] fast_reg_sel
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	// Table slot of the entry under way, in 64-bit words.
	wire [15:0] slot = {12'h000, int_number, 1'b0};

	a_exec_on_load: assert property (link_load |-> machine_status[13] && !entry_flag && $past(entry_flag))
		else $error("link load without executive mode or entry end");
	a_save_addr: assert property (store_req && store_we |-> store_addr == 16'h0010 + slot)
		else $error("link saved to wrong table word");
	a_load_addr: assert property (store_req && !store_we |-> store_addr == 16'h0011 + slot)
		else $error("new link read from wrong table word");
	a_store_in_entry: assert property (store_req |-> entry_flag && halt_req && bypass_name_store && priv_access)
		else $error("store access outside a protected entry");
	a_held_req: assert property (store_req && !store_ack |=> store_req && $stable(store_addr))
		else $error("store request dropped before its answer");
	a_ic_stop: assert property (ic_stopped == (machine_status[10] || machine_status[14] || machine_status[15] || entry_flag))
		else $error("counter stop does not follow status");
	a_priv_when: assert property (priv_access == (machine_status[13] || machine_status[14] || machine_status[15] || entry_flag))
		else $error("privilege does not follow status");
	a_drain_first: assert property ($rose(store_req) && int_number != 3'h1 |-> $past(pipe_idle))
		else $error("link saved before the pipeline drained");
	a_fast_regs: assert property ($past(arst_n) |-> fast_reg_hit == $past(machine_status[15]) && fast_reg_sel == $past(opnd_addr[2:0]))
		else $error("fast register select wrong");
endmodule // ies_entry_chk

bind ies_entry_ctrl ies_entry_chk i_chk (.clk_sys(clk_sys), .arst_n(arst_n), .pipe_idle(pipe_idle),
	.halt_req(halt_req), .entry_flag(entry_flag), .store_req(store_req), .store_we(store_we),
	.store_addr(store_addr), .store_ack(store_ack), .link_load(link_load), .int_number(int_number),
	.machine_status(machine_status), .priv_access(priv_access), .bypass_name_store(bypass_name_store),
	.ic_stopped(ic_stopped), .opnd_addr(opnd_addr), .fast_reg_hit(fast_reg_hit), .fast_reg_sel(fast_reg_sel));

/* File: test/ies_store_model.sv */
`timescale 1ns/1ps
// Store side and pipeline drain of the processor, answering after lat cycles.
module ies_store_model (
	input wire clk_sys,
	input wire arst_n,
	input wire [3:0] lat,
	input wire halt_req,
	input wire store_req,
	input wire store_we,
	input wire [15:0] store_addr,
	input wire [63:0] store_wdata,
	output reg store_ack,
	output reg [63:0] store_rdata,
	output reg pipe_idle,
	output reg [15:0] last_addr,
	output reg [63:0] last_wdata
);
	reg [3:0] cnt_reg;
	reg [3:0] idle_reg;
	wire answer = store_req && !store_ack && cnt_reg == lat;
	// Read data is scrambled outside the answer cycle so a late sample cannot pass by luck.
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 4'h0;
			idle_reg <= 4'h0;
			store_ack <= 1'b0;
			store_rdata <= 64'h0;
			pipe_idle <= 1'b0;
			last_addr <= 16'h0;
			last_wdata <= 64'h0;
		end else begin
			store_ack <= answer;
			cnt_reg <= (store_req && !store_ack && cnt_reg != lat) ? cnt_reg + 4'h1 : 4'h0;
			store_rdata <= ~store_rdata;
			if (answer && !store_we)
				store_rdata <= {16'h0000, 16'h1000 | store_addr, 16'h2000, store_addr};
			if (store_ack && store_we) begin
				last_addr <= store_addr;
				last_wdata <= store_wdata;
			end
			pipe_idle <= halt_req && idle_reg == lat;
			idle_reg <= !halt_req ? 4'h0 : (idle_reg != lat) ? idle_reg + 4'h1 : idle_reg;
		end
	end
endmodule // ies_store_model

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
	reg clk_sys = 1'b0;
	reg arst_n = 1'b0;
	reg [11:0] ev = 12'h000;
	reg xc_exec = 1'b0;
	reg ms_wr = 1'b0;
	reg [15:0] ms_wmask = 16'h0000;
	reg [15:0] ms_wdata = 16'h0000;
	reg [15:0] nb = 16'h0000;
	reg [31:0] ca = 32'h0000_0000;
	reg [15:0] opnd_addr = 16'h0000;
	reg [7:0] reg_addr = 8'h00;
	reg [15:0] reg_wdata = 16'h0000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [3:0] lat = 4'h0;
	reg [14:0] rows [0:11];
	reg got;
	integer i;
	integer n_errors = 0;
	integer check_count = 0;
	wire halt_req, entry_flag, store_req, store_we, store_ack, pipe_idle, link_load;
	wire priv_access, bypass_page_regs, bypass_name_store, ic_stopped, fast_reg_hit;
	wire [15:0] store_addr, new_name_base, machine_status, reg_rdata, last_addr;
	wire [63:0] store_wdata, store_rdata, last_wdata;
	wire [31:0] new_control_address;
	wire [2:0] int_number, fast_reg_sel;

	ies_entry_ctrl i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ev_cpr_neq(ev[0]), .ev_exchange(ev[1]),
		.ev_periph(ev[2]), .ev_software(ev[3]), .ev_ill_order(ev[4]), .ev_fault_bd(ev[5]), .ev_fault_acc(ev[6]),
		.ev_fault_other(ev[7]), .ev_ill_func(ev[8]), .ev_hw_error(ev[9]), .ev_console(ev[10]),
		.ins_retired(ev[11]), .pipe_idle(pipe_idle), .xc_exec(xc_exec), .ms_wr(ms_wr), .ms_wmask(ms_wmask),
		.ms_wdata(ms_wdata), .cur_name_base(nb), .cur_control_address(ca), .halt_req(halt_req),
		.entry_flag(entry_flag), .store_req(store_req), .store_we(store_we), .store_addr(store_addr),
		.store_wdata(store_wdata), .store_ack(store_ack), .store_rdata(store_rdata), .link_load(link_load),
		.new_name_base(new_name_base), .new_control_address(new_control_address), .int_number(int_number),
		.machine_status(machine_status), .priv_access(priv_access), .bypass_page_regs(bypass_page_regs),
		.bypass_name_store(bypass_name_store), .ic_stopped(ic_stopped), .opnd_addr(opnd_addr),
		.fast_reg_hit(fast_reg_hit), .fast_reg_sel(fast_reg_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	ies_store_model i_store (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat), .halt_req(halt_req),
		.store_req(store_req), .store_we(store_we), .store_addr(store_addr), .store_wdata(store_wdata),
		.store_ack(store_ack), .store_rdata(store_rdata), .pipe_idle(pipe_idle), .last_addr(last_addr),
		.last_wdata(last_wdata));

	// Free-running clock of the processor.
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Operand addresses keep moving so the fast register select is always exercised.
	always @(posedge clk_sys) begin
		opnd_addr <= opnd_addr + 16'h0001;
	end

	task chk(input [63:0] got_v, input [63:0] exp_v);
		begin
			check_count = check_count + 1;
			if (got_v !== exp_v) begin
				n_errors = n_errors + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
			end
		end
	endtask

	task reg_write(input [7:0] a, input [15:0] d);
		begin
			@(posedge clk_sys);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask

	// Read data stands only in the cycle after the strobe, so it is sampled just after that edge.
	task rd_chk(input [7:0] a, input [15:0] e);
		begin
			@(posedge clk_sys);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1;
			chk(reg_rdata, e);
		end
	endtask

	task pulse(input [11:0] v);
		begin
			@(posedge clk_sys);
			ev <= v;
			@(posedge clk_sys);
			ev <= 12'h000;
		end
	endtask

	// Bounded wait for the end of an entry; a blocked entry simply reports none.
	task wait_link(output reg seen);
		integer k;
		begin
			seen = 1'b0;
			for (k = 0; k < 60 && !seen; k = k + 1) begin
				@(posedge clk_sys);
				#1;
				if (link_load === 1'b1)
					seen = 1'b1;
			end
		end
	endtask

	task end_sim;
		begin
			if (n_errors == 0 && check_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	// A hang is cut short at 30000 cycles, well beyond the few hundred cycles the run needs.
	initial begin
		#300000;
		n_errors = n_errors + 1;
		end_sim;
	end

	initial begin
		rows[0] = {12'h001, 3'h1};
		rows[1] = {12'h002, 3'h2};
		rows[2] = {12'h004, 3'h3};
		rows[3] = {12'h008, 3'h7};
		rows[4] = {12'h010, 3'h5};
		rows[5] = {12'h020, 3'h6};
		rows[6] = {12'h040, 3'h6};
		rows[7] = {12'h080, 3'h6};
		rows[8] = {12'h100, 3'h5};
		rows[9] = {12'h800, 3'h4};
		rows[10] = {12'h200, 3'h0};
		rows[11] = {12'h400, 3'h0};
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		// Each cause from user mode, with the store latency stepping through 0 to 3 cycles in turn.
		for (i = 0; i < 12; i = i + 1) begin
			reg_write(8'h00, 16'h0000);
			reg_write(8'h10, 16'h0001);
			lat <= {2'h0, i[1:0]};
			nb <= 16'h0a00 + i[15:0];
			ca <= 32'h4000_0000 + i;
			pulse(rows[i][14:3]);
			wait_link(got);
			chk(got, 1);
			chk(int_number, rows[i][2:0]);
			chk(last_addr, 16'h0010 + {12'h000, rows[i][2:0], 1'b0});
			chk(last_wdata, {16'h0000, nb, ca});
			chk(new_control_address, 32'h2000_0011 + {28'h0, rows[i][2:0], 1'b0});
			chk(new_name_base, 16'h1011 + {12'h000, rows[i][2:0], 1'b0});
			rd_chk(8'h00, 16'h2000);
		end
		// A second system error before any clearing write must not be entered.
		chk(bypass_page_regs, 1);
		rd_chk(8'h08, 16'h0003);
		pulse(12'h200);
		wait_link(got);
		chk(got, 0);
		// Reset in mid-run brings everything back to rest.
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd_chk(8'h00, 16'h0000);
		rd_chk(8'h08, 16'h0000);
		rd_chk(8'h1a, 16'h0000);
		rd_chk(8'h04, 16'h0000);
		// User writes reach only the user bits; an executive call opens the rest.
		reg_write(8'h00, 16'hffff);
		rd_chk(8'h00, 16'h00f3);
		// A masked write from the pipeline is held to the user bits as well.
		@(posedge clk_sys);
		ms_wr <= 1'b1;
		ms_wmask <= 16'hff0f;
		ms_wdata <= 16'h0000;
		@(posedge clk_sys);
		ms_wr <= 1'b0;
		rd_chk(8'h00, 16'h00f0);
		@(posedge clk_sys);
		xc_exec <= 1'b1;
		@(posedge clk_sys);
		xc_exec <= 1'b0;
		rd_chk(8'h00, 16'h20f0);
		// Level 0 maps operands to fast registers and turns a page mismatch into a system error.
		reg_write(8'h00, 16'h8800);
		rd_chk(8'h00, 16'h8800);
		chk(fast_reg_hit, 1);
		pulse(12'h001);
		wait_link(got);
		chk(got, 1);
		chk(int_number, 3'h0);
		rd_chk(8'h08, 16'h2000);
		reg_write(8'h08, 16'h0000);
		reg_write(8'h00, 16'h0800);
		rd_chk(8'h00, 16'h0800);
		pulse(12'h020);
		wait_link(got);
		chk(got, 1);
		chk(int_number, 3'h0);
		rd_chk(8'h08, 16'h0100);
		// Three causes at once are pending together and entered lowest first.
		reg_write(8'h00, 16'h0000);
		pulse(12'h007);
		rd_chk(8'h1a, 16'h000e);
		for (i = 1; i < 4; i = i + 1) begin
			wait_link(got);
			chk(int_number, i[2:0]);
		end
		end_sim;
	end
endmodule // tb
